// ===== design/scl_loader.sv
`timescale 1ns/1ps
`include "scl_defs.svh"

// Summary of operation
// - Each transfer is a 24-bit word; low four bits carry the address code.
// - Strobe rising edge copies the shift register into the addressed latch only.
// - Even code selects latch zero; odd codes select latches one to eight.
// - Divider word load restarts lock-detect and fast-lock counters, nothing else.
// - Two-bit modulator order field; value 3 is third order, dither off start.
// - Three-bit pump trim and two-bit dither fields sit beside modulator order.
// - Latches zero to three basic lock settings; remaining five optional tuning.

module scl_loader
    import scl_pkg::*;
#(
    parameter int NUM_LATCH    = `SCL_NUM_LATCH,
    parameter bit EXT_MODULUS  = 1'b0
) (
    // System
    input  wire logic              mclk,
    input  wire logic              rst,
    // Serial link
    input  wire logic              sclk,
    input  wire logic              sdata,
    input  wire logic              latch_strobe,
    // Configuration latches
    output scl_pkg::scl_word_t     basic_cfg_zero,
    output scl_pkg::scl_word_t     basic_cfg_one,
    output scl_pkg::scl_word_t     basic_cfg_two,
    output scl_pkg::scl_word_t     basic_cfg_three,
    output scl_pkg::scl_word_t     adv_cfg_four,
    output scl_pkg::scl_word_t     adv_cfg_five,
    output scl_pkg::scl_word_t     adv_cfg_six,
    output scl_pkg::scl_word_t     adv_cfg_seven,
    output scl_pkg::scl_word_t     adv_cfg_eight,
    // Spur-control fields
    output logic [1:0]             modulator_order_field,
    output logic [2:0]             pump_trim_field,
    output logic [1:0]             dither_select_field,
    // Counter restarts
    output logic                   lock_detect_restart,
    output logic                   fastlock_restart,
    // Load status
    output logic                   basic_set_done,
    output logic                   full_set_done
);

    import scl_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    scl_word_t          shift_word;
    logic               strobe_meta;
    logic               strobe_sync;
    logic               strobe_prev;
    logic               strobe_rise;
    scl_state_t         state;
    scl_state_t         next_state;
    scl_word_t          hold_word;
    scl_word_t          next_hold_word;
    scl_idx_t           hold_idx;
    scl_idx_t           next_hold_idx;
    logic               commit;
    logic [3:0]         latch_address_code;
    scl_word_t          cfg_q    [NUM_LATCH];
    scl_word_t          next_cfg [NUM_LATCH];
    logic [8:0]         wr_seen;
    logic [8:0]         next_wr_seen;
    logic [8:0]         req_mask;
    logic               restart_q;
    logic               next_restart;
    logic               next_basic_done;
    logic               next_full_done;

    // ------------------------------------------------------------------------
    // Serial clock domain
    // ------------------------------------------------------------------------
    scl_shift #(
        .WIDTH      (`SCL_WORD_W)
    ) u_shift (
        .sclk       (sclk),
        .sdata      (sdata),
        .shift_word (shift_word)
    );

    // ------------------------------------------------------------------------
    // Strobe synchroniser
    // ------------------------------------------------------------------------
    // Word crosses as a quasi-static value qualified by the synced strobe;
    // host keeps the serial clock idle while the strobe is high
    always_ff @(posedge mclk) begin
        if (rst) begin
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            strobe_prev <= 1'b0;
        end else begin
            strobe_meta <= latch_strobe;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
        end
    end

    assign strobe_rise = strobe_sync & ~strobe_prev;

    // ------------------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_hold_word = hold_word;
        next_hold_idx  = hold_idx;
        unique case (state)
            SCL_ST_WAIT: begin
                if (strobe_rise) begin
                    next_hold_word = shift_word;
                    next_hold_idx  = scl_decode(shift_word[3:0]);
                    next_state     = SCL_ST_COMMIT;
                end
            end
            SCL_ST_COMMIT: begin
                next_state = SCL_ST_WAIT;
            end
            default: begin
                next_state = SCL_ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state     <= SCL_ST_WAIT;
            hold_word <= `SCL_RST_LATCH;
            hold_idx  <= 4'h0;
        end else begin
            state     <= next_state;
            hold_word <= next_hold_word;
            hold_idx  <= next_hold_idx;
        end
    end

    assign commit             = (state == SCL_ST_COMMIT);
    assign latch_address_code = hold_word[`SCL_ADDR_MSB:`SCL_ADDR_LSB];

    // ------------------------------------------------------------------------
    // Configuration latches
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LATCH; gi++) begin : g_latch
            localparam scl_word_t RST_VAL =
                (gi == `SCL_FIELD_LATCH) ? `SCL_RST_FIELD : `SCL_RST_LATCH;

            always_comb begin
                next_cfg[gi] = cfg_q[gi];
                if (commit && (hold_idx == 4'(gi))) begin
                    next_cfg[gi] = hold_word;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cfg_q[gi] <= RST_VAL;
                end else begin
                    cfg_q[gi] <= next_cfg[gi];
                end
            end

            chk_latch_untouched: assert property (
                @(posedge mclk) disable iff (rst)
                !(commit && (hold_idx == 4'(gi))) |=> $stable(cfg_q[gi])
            ) else $error("latch changed without a matching commit");
        end
    endgenerate

    assign basic_cfg_zero  = cfg_q[0];
    assign basic_cfg_one   = cfg_q[1];
    assign basic_cfg_two   = cfg_q[2];
    assign basic_cfg_three = cfg_q[3];
    assign adv_cfg_four    = cfg_q[4];
    assign adv_cfg_five    = cfg_q[5];
    assign adv_cfg_six     = cfg_q[6];
    assign adv_cfg_seven   = cfg_q[7];
    assign adv_cfg_eight   = cfg_q[8];

    // ------------------------------------------------------------------------
    // Spur-control fields
    // ------------------------------------------------------------------------
    // Field latch resets to third order with dither off
    assign modulator_order_field =
        cfg_q[`SCL_FIELD_LATCH][`SCL_ORDER_MSB:`SCL_ORDER_LSB];
    assign pump_trim_field =
        cfg_q[`SCL_FIELD_LATCH][`SCL_TRIM_MSB:`SCL_TRIM_LSB];
    assign dither_select_field =
        cfg_q[`SCL_FIELD_LATCH][`SCL_DITHER_SELECT_FIELD_MSB:`SCL_DITHER_SELECT_FIELD_LSB];

    // ------------------------------------------------------------------------
    // Counter restart and load tracking
    // ------------------------------------------------------------------------
    // Latch seven only counts when the extended modulus is in use
    assign req_mask = EXT_MODULUS ? `SCL_REQ_MASK_EXT : `SCL_REQ_MASK_STD;

    always_comb begin
        next_restart = commit && (hold_idx == `SCL_DIV_LATCH);
        next_wr_seen = wr_seen;
        if (commit) begin
            next_wr_seen = wr_seen | (9'h001 << hold_idx);
        end
        next_basic_done = &next_wr_seen[`SCL_NUM_BASIC-1:0];
        next_full_done  = ((next_wr_seen & req_mask) == req_mask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            restart_q      <= 1'b0;
            wr_seen        <= 9'h000;
            basic_set_done <= 1'b0;
            full_set_done  <= 1'b0;
        end else begin
            restart_q      <= next_restart;
            wr_seen        <= next_wr_seen;
            basic_set_done <= next_basic_done;
            full_set_done  <= next_full_done;
        end
    end

    // Both counter groups restart together; stored values are untouched
    assign lock_detect_restart = restart_q;
    assign fastlock_restart    = restart_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_word_whole: assert property (
        @(posedge mclk) disable iff (rst)
        commit |=> (cfg_q[$past(hold_idx)] == $past(hold_word))
    ) else $error("committed latch does not hold the full word");

    chk_strobe_commit: assert property (
        @(posedge mclk) disable iff (rst)
        (state == SCL_ST_WAIT) && strobe_rise
            |=> commit ##1 (state == SCL_ST_WAIT)
    ) else $error("strobe rise did not give exactly one commit");

    chk_capture_word: assert property (
        @(posedge mclk) disable iff (rst)
        (state == SCL_ST_WAIT) && strobe_rise
            |=> (hold_word == $past(shift_word))
    ) else $error("held word differs from shift register at strobe");

    chk_addr_even: assert property (
        @(posedge mclk) disable iff (rst)
        commit && !latch_address_code[0] |-> (hold_idx == 4'h0)
    ) else $error("even address code not mapped to latch zero");

    chk_addr_odd: assert property (
        @(posedge mclk) disable iff (rst)
        commit && latch_address_code[0]
            |-> (hold_idx == ({1'b0, latch_address_code[3:1]} + 4'h1))
    ) else $error("odd address code mapped to wrong latch");

    chk_restart_cause: assert property (
        @(posedge mclk) disable iff (rst)
        commit && (hold_idx == `SCL_DIV_LATCH)
            |=> lock_detect_restart && fastlock_restart ##1 !lock_detect_restart
    ) else $error("divider load did not give a one-cycle restart");

    chk_restart_only: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(lock_detect_restart) |-> $past(commit) && ($past(hold_idx) == 4'h0)
    ) else $error("restart pulse without a divider load");

    chk_order_reset: assert property (
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> (modulator_order_field == `SCL_ORDER_THIRD)
            && (dither_select_field == `SCL_DITHER_SELECT_FIELD_OFF)
    ) else $error("fields not at third order, dither off after reset");

    chk_field_update: assert property (
        @(posedge mclk) disable iff (rst)
        commit && (hold_idx == `SCL_FIELD_LATCH)
            |=> (pump_trim_field == $past(hold_word[6:4]))
            && (modulator_order_field == $past(hold_word[8:7]))
            && (dither_select_field == $past(hold_word[10:9]))
    ) else $error("spur fields did not follow the field latch load");

    chk_basic_rise: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(basic_set_done) |-> $past(commit) && ($past(hold_idx) < 4'h4)
    ) else $error("basic set completed by a non-basic latch");

    chk_done_sticky: assert property (
        @(posedge mclk) disable iff (rst)
        basic_set_done |=> basic_set_done
    ) else $error("basic set flag dropped without reset");

endmodule // scl_loader

// ===== design/scl_shift.sv
`timescale 1ns/1ps

module scl_shift #(
    parameter int WIDTH = 24
) (
    // Link side
    input  wire logic             sclk,
    input  wire logic             sdata,
    // Captured word
    output logic [WIDTH-1:0]      shift_word
);

    logic [WIDTH-1:0] next_shift;

    // --------------------------------------------------------------------
    // Shift path
    // --------------------------------------------------------------------
    // Newest bit enters at the bottom, so the first bit ends at the top
    always_comb begin
        next_shift = {shift_word[WIDTH-2:0], sdata};
    end

    // No reset: link clock may never run before the first frame
    always_ff @(posedge sclk) begin
        shift_word <= next_shift;
    end

endmodule // scl_shift

// ===== pkg/scl_defs.svh
`ifndef SCL_DEFS_SVH
`define SCL_DEFS_SVH

// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define SCL_WORD_W          24
`define SCL_ADDR_W          4
`define SCL_ADDR_LSB        0
`define SCL_ADDR_MSB        3
`define SCL_NUM_LATCH       9
`define SCL_NUM_BASIC       4

// ----------------------------------------------------------------------------
// Latch roles
// ----------------------------------------------------------------------------
`define SCL_DIV_LATCH       4'h0
`define SCL_FIELD_LATCH     4'h5
`define SCL_EXT_LATCH       4'h7

// ----------------------------------------------------------------------------
// Spur-control field positions inside the field latch
// ----------------------------------------------------------------------------
`define SCL_TRIM_LSB        4
`define SCL_TRIM_MSB        6
`define SCL_ORDER_LSB       7
`define SCL_ORDER_MSB       8
`define SCL_DITHER_SELECT_FIELD_LSB        9
`define SCL_DITHER_SELECT_FIELD_MSB        10
`define SCL_ORDER_THIRD     2'h3
`define SCL_DITHER_SELECT_FIELD_OFF        2'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SCL_RST_LATCH       24'h000000
`define SCL_RST_FIELD       24'h000189
`define SCL_REQ_MASK_STD    9'h17F
`define SCL_REQ_MASK_EXT    9'h1FF

`endif

// ===== pkg/scl_pkg.sv
`include "scl_defs.svh"

package scl_pkg;

    typedef logic [`SCL_WORD_W-1:0] scl_word_t;
    typedef logic [3:0]             scl_idx_t;

    typedef enum logic [1:0] {
        SCL_ST_WAIT   = 2'b01,
        SCL_ST_COMMIT = 2'b10
    } scl_state_t;

    // Even code always lands in latch zero
    function automatic scl_idx_t scl_decode(input logic [`SCL_ADDR_W-1:0] code);
        if (!code[0]) begin
            scl_decode = 4'h0;
        end else begin
            scl_decode = {1'b0, code[3:1]} + 4'h1;
        end
    endfunction

endpackage

// ===== verif/scl_host_model.sv
`timescale 1ns/1ps

module scl_host_model (
    // Board clock, used only to place the strobe
    input  wire logic          mclk,
    // Link pins
    output logic               sclk,
    output logic               sdata,
    output logic               latch_strobe
);
    import scl_pkg::*;

    initial begin
        sclk         = 1'b0;
        sdata        = 1'b0;
        latch_strobe = 1'b0;
    end

    // Link clock runs only inside a frame, 15 ns period
    task automatic shift_word(input scl_pkg::scl_word_t word);
        for (int b = `SCL_WORD_W - 1; b >= 0; b--) begin
            sdata = word[b];
            #7.5;
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
        end
        // Released line shows the inverse, never a stale copy
        sdata = ~word[0];
    endtask

    // Strobe held high and link quiet long enough for the commit to land
    task automatic pulse_strobe();
        @(posedge mclk);
        #2;
        latch_strobe = 1'b1;
        repeat (6) @(posedge mclk);
        #2;
        latch_strobe = 1'b0;
        repeat (4) @(posedge mclk);
        // Step off the edge so callers see settled outputs
        #2;
    endtask

    task automatic send_word(input scl_pkg::scl_word_t word);
        shift_word(word);
        pulse_strobe();
    endtask
endmodule // scl_host_model

// ===== verif/test_serial_config_loader.sv
`timescale 1ns/1ps
`include "scl_defs.svh"

`define SCL_CHECK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end

module test_serial_config_loader;
    import scl_pkg::*;

    logic       mclk = 1'b0;
    logic       rst;
    logic       sclk;
    logic       sdata;
    logic       latch_strobe;
    scl_word_t  lat [`SCL_NUM_LATCH];
    scl_word_t  exp_lat [`SCL_NUM_LATCH];
    logic [8:0] seen;
    logic [1:0] order_f;
    logic [2:0] trim_f;
    logic [1:0] dither_select_field_f;
    logic       ld_rst;
    logic       fl_rst;
    logic       basic_done;
    logic       full_done;
    int         n_errors = 0;
    int         n_checks = 0;
    int         n_ld     = 0;
    int         n_fl     = 0;
    int         exp_ld   = 0;

    always #12.5 mclk = ~mclk;

    scl_host_model i_host (
        .mclk         (mclk),
        .sclk         (sclk),
        .sdata        (sdata),
        .latch_strobe (latch_strobe)
    );

    scl_loader #(
        .NUM_LATCH   (`SCL_NUM_LATCH),
        .EXT_MODULUS (1'b0)
    ) i_dut (
        .mclk                  (mclk),
        .rst                   (rst),
        .sclk                  (sclk),
        .sdata                 (sdata),
        .latch_strobe          (latch_strobe),
        .basic_cfg_zero        (lat[0]),
        .basic_cfg_one         (lat[1]),
        .basic_cfg_two         (lat[2]),
        .basic_cfg_three       (lat[3]),
        .adv_cfg_four          (lat[4]),
        .adv_cfg_five          (lat[5]),
        .adv_cfg_six           (lat[6]),
        .adv_cfg_seven         (lat[7]),
        .adv_cfg_eight         (lat[8]),
        .modulator_order_field (order_f),
        .pump_trim_field       (trim_f),
        .dither_select_field   (dither_select_field_f),
        .lock_detect_restart   (ld_rst),
        .fastlock_restart      (fl_rst),
        .basic_set_done        (basic_done),
        .full_set_done         (full_done)
    );

    // A pulse wider than one cycle counts twice and shows up as a mismatch
    always @(posedge mclk) begin
        if (ld_rst === 1'b1) n_ld++;
        if (fl_rst === 1'b1) n_fl++;
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic init_exp();
        for (int i = 0; i < `SCL_NUM_LATCH; i++) exp_lat[i] = `SCL_RST_LATCH;
        exp_lat[`SCL_FIELD_LATCH] = `SCL_RST_FIELD;
        seen = 9'h000;
    endtask

    task automatic check_all();
        for (int i = 0; i < `SCL_NUM_LATCH; i++) begin
            `SCL_CHECK("latch", exp_lat[i], lat[i])
        end
        `SCL_CHECK("order", exp_lat[5][`SCL_ORDER_MSB:`SCL_ORDER_LSB], order_f)
        `SCL_CHECK("trim", exp_lat[5][`SCL_TRIM_MSB:`SCL_TRIM_LSB], trim_f)
        `SCL_CHECK("dither", exp_lat[5][`SCL_DITHER_SELECT_FIELD_MSB:`SCL_DITHER_SELECT_FIELD_LSB], dither_select_field_f)
        `SCL_CHECK("basic done", &seen[3:0], basic_done)
        `SCL_CHECK("full done", &{seen[8], seen[6:0]}, full_done)
        `SCL_CHECK("lock restarts", exp_ld, n_ld)
        `SCL_CHECK("fastlock restarts", exp_ld, n_fl)
    endtask

    task automatic write_code(input logic [3:0] code);
        scl_word_t w;
        scl_idx_t  idx;
        w   = {code, 4'h9, code, 8'hC3, code};
        idx = code[0] ? {1'b0, code[3:1]} + 4'h1 : 4'h0;
        exp_lat[idx] = w;
        seen[idx]    = 1'b1;
        if (idx == 4'h0) exp_ld++;
        i_host.send_word(w);
        check_all();
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge mclk);
        #2;
        rst = 1'b0;
        @(posedge mclk);
        #2;
        init_exp();
        check_all();
        $display("test reset values done");
        // Bits shifted with no strobe must not reach any latch
        i_host.shift_word(24'hFFFFF1);
        repeat (4) @(posedge mclk);
        check_all();
        $display("test shift only done");
        // Power-up set with the extended latch skipped, divider word last
        for (int c = 1; c < 16; c++) begin
            if (c != 13) write_code(4'(c));
        end
        write_code(4'h0);
        $display("test power-up sequence done");
        // Even codes 2 to 14 land in latch zero and restart the counters
        for (int c = 2; c < 16; c += 2) write_code(4'(c));
        write_code(4'hD);
        $display("test address decode done");
        // Second reset in mid-run restores the start-up contents
        @(posedge mclk);
        #2;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #2;
        rst = 1'b0;
        @(posedge mclk);
        #2;
        init_exp();
        check_all();
        write_code(4'h9);
        $display("test mid-run reset done");
        test_done();
    end

    // Whole run needs about 15 us; a hang is cut off well past that
    initial begin
        #100us;
        n_errors++;
        $display("unexpected timeout: expected end of tests seen none");
        test_done();
    end
endmodule // test_serial_config_loader
